/* File: rtl/dsp_core_pkg.sv */
// constants, modes and command layout for the signal-processor datapath
package dsp_core_pkg;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] PTR_RESET = 3'h0;
  localparam int AUX_COUNT = 8;
  localparam int LOW_TOP = 15;
  localparam int HIGH_LOW = 16;
  localparam logic [4:0] HALF_SHIFT = 5'h10;
  localparam logic [4:0] SCALE_MAX = 5'h10;
  localparam int VAR_SHIFT_BITS = 4;
  localparam logic [1:0] PROD_NONE = 2'h0;
  localparam logic [1:0] PROD_LEFT1 = 2'h1;
  localparam logic [1:0] PROD_LEFT4 = 2'h2;
  localparam logic [1:0] PROD_RIGHT6 = 2'h3;
  localparam int PROD_SHIFT_SMALL = 1;
  localparam int PROD_SHIFT_MID = 4;
  localparam int PROD_SHIFT_RIGHT = 6;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD_SHIFTED, OP_SUB_SHIFTED, OP_LOAD_SHIFTED,
    OP_ADD_PRODUCT, OP_ADD_BUFFER, OP_SAVE_BUFFER, OP_KEEP_MIN,
    OP_KEEP_MAX, OP_SHIFT_RIGHT, OP_LEFT_JUSTIFY, OP_LOAD_OPERAND,
    OP_MUL_SIGNED, OP_MUL_UNSIGNED, OP_MUL_ACC, OP_MUL_ACC_MOVE,
    OP_REPEAT_CLEAR, OP_STORE_HIGH, OP_STORE_LOW, OP_BIT_LOGIC,
    OP_LOAD_AUX, OP_LOAD_INDEX, OP_LOAD_SHIFT_COUNT
  } op_type;

  typedef enum logic [1:0] {BIT_SET, BIT_CLEAR, BIT_TEST, BIT_TOGGLE} bit_op_type;
  typedef enum logic [2:0] {AR_HOLD, AR_INC, AR_DEC, AR_ADD_INDEX, AR_SUB_INDEX} addr_mode_type;
  typedef enum logic [1:0] {AUX_FROM_DATA, AUX_FROM_ACC, AUX_FROM_PROD, AUX_FROM_IMM} aux_src_type;

  // one decoded instruction step
  typedef struct packed {
    op_type op;
    logic [4:0] shift;
    logic var_shift;
    logic [2:0] post_shift;
    bit_op_type bit_op;
    addr_mode_type addr_mode;
    aux_src_type aux_src;
    logic [2:0] ptr_next;
    logic ptr_load;
    logic [15:0] imm;
  } cmd_type;

  // mode bits of the second status word
  typedef struct packed {
    logic sign_extend_mode_bit;
    logic [1:0] product_shift_field;
  } status_word_two_type;
endpackage

/* File: rtl/dsp_core_datapath.sv */
// arithmetic datapath: accumulator, multiplier, bit logic and address unit
// Notes on behaviour
// - alu adds accumulator to product, buffer, or shifter
// - stored half gets left shift zero to seven
// - low store fills vacated bits with zeros
// - left justify shifts accumulator left
// - variable shift uses four shift count bits
// - accumulator right shift by zero to thirty-one
// - save buffer copies accumulator, feeds alu
// - min/max fills both registers, sets carry
// - scaling shifter shifts data left zero to sixteen
// - low fill zeros, high fill per sign mode
// - bit logic edits memory, accumulator untouched
// - single-cycle product, signed except unsigned multiply
// - operand register and product register hold values
// - product shift: left one, four, right six
// - load then multiply gives product per two cycles
// - mac takes coefficient and data each cycle
// - repeat clear zeroes accumulator and product
// - moving mac shifts sample up one location
// - three-bit pointer selects one of eight registers
// - address unit steps by one or index
// - auxiliary registers loadable and readable in data space
`timescale 1ns/1ps
module dsp_core_datapath (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // decoded instruction
  input wire logic cmd_valid,
  input dsp_core_pkg::cmd_type cmd,
  input dsp_core_pkg::status_word_two_type status_word_two,
  // bus inputs
  input wire logic [15:0] data_in,
  input wire logic [15:0] coeff_in,
  input wire logic [2:0] map_select,
  // write port toward data memory
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  // address and mapped read
  output logic [15:0] data_addr,
  output logic [15:0] map_value,
  output logic [2:0] pointer_select,
  // arithmetic state
  output logic [31:0] running_total_register,
  output logic [31:0] save_buffer,
  output logic [31:0] product_register,
  output logic [15:0] multiplier_operand_register,
  output logic [15:0] shift_count_register,
  output logic [15:0] index_step_register,
  output logic carry,
  output logic test_flag
);
  import dsp_core_pkg::*;
  logic [15:0] auxiliary_pointer_regs [AUX_COUNT];
  logic go; // a command is taken this cycle
  logic [4:0] scale_amt; // scaling shifter count
  logic [31:0] extended; // data word widened per sign mode
  logic [31:0] scaled; // scaling shifter output
  logic [31:0] prod_out; // product register after shift mode
  logic [31:0] operand_b; // second alu operand
  logic [32:0] sum33, diff33; // add and subtract, with carry or borrow out
  logic signed [31:0] mul_signed; // operand times data, signed
  logic [31:0] mul_unsigned; // operand times data, unsigned
  logic signed [31:0] mac_product; // data times coefficient
  logic [15:0] cur_aux, aux_load, aux_step; // selected entry, its load value, its stepped value
  logic [15:0] bit_result; // bit logic unit output
  logic justify_now; // accumulator not yet left-justified
  logic acc_lt_buf; // signed compare for min and max
  assign go = cmd_valid;
  assign cur_aux = auxiliary_pointer_regs[pointer_select];
  // scaling shifter: count from the command or the shift count register
  assign scale_amt = cmd.var_shift ? {1'b0, shift_count_register[VAR_SHIFT_BITS-1:0]}
                                   : cmd.shift;
  // high fill follows the sign mode; the shift itself brings zeros in low
  assign extended = status_word_two.sign_extend_mode_bit ? {{16{data_in[15]}}, data_in}
                                                         : {16'h0000, data_in};
  // counts above sixteen are clamped so a bad decode cannot clear the word
  assign scaled = extended << ((scale_amt > SCALE_MAX) ? SCALE_MAX : scale_amt);
  // product shift modes at the product register output
  always_comb begin
    unique case (status_word_two.product_shift_field)
      PROD_NONE: prod_out = product_register;
      PROD_LEFT1: prod_out = product_register << PROD_SHIFT_SMALL;
      PROD_LEFT4: prod_out = product_register << PROD_SHIFT_MID;
      PROD_RIGHT6: prod_out = 32'($signed(product_register) >>> PROD_SHIFT_RIGHT);
    endcase
  end
  // second alu operand: product, buffer, or scaled data
  always_comb begin
    unique case (cmd.op)
      OP_ADD_PRODUCT, OP_MUL_ACC, OP_MUL_ACC_MOVE: operand_b = prod_out;
      OP_ADD_BUFFER: operand_b = save_buffer;
      default: operand_b = scaled;
    endcase
  end
  assign sum33 = {1'b0, running_total_register} + {1'b0, operand_b};
  assign diff33 = {1'b0, running_total_register} - {1'b0, operand_b};
  assign mul_signed = $signed(multiplier_operand_register) * $signed(data_in);
  assign mul_unsigned = multiplier_operand_register * data_in;
  assign mac_product = $signed(data_in) * $signed(coeff_in);
  assign acc_lt_buf = $signed(running_total_register) < $signed(save_buffer);
  // justify while the two top bits agree and the value is not zero
  assign justify_now = (running_total_register[31] == running_total_register[30])
                       && (running_total_register != ACC_RESET);
  // accumulator: every alu result lands here; stores leave it alone
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      running_total_register <= ACC_RESET;
    end else if (go) begin
      unique case (cmd.op)
        OP_ADD_SHIFTED, OP_ADD_PRODUCT, OP_ADD_BUFFER,
        OP_MUL_ACC, OP_MUL_ACC_MOVE: running_total_register <= sum33[31:0];
        OP_SUB_SHIFTED: running_total_register <= diff33[31:0];
        OP_LOAD_SHIFTED: running_total_register <= scaled;
        OP_SHIFT_RIGHT: begin
          // one-cycle barrel shift; arithmetic when sign mode is set
          if (status_word_two.sign_extend_mode_bit) begin
            running_total_register <= 32'($signed(running_total_register) >>> cmd.shift);
          end else begin
            running_total_register <= running_total_register >> cmd.shift;
          end
        end
        OP_LEFT_JUSTIFY: begin
          if (justify_now) begin
            running_total_register <= running_total_register << 1;
          end
        end
        OP_KEEP_MIN: begin
          if (!acc_lt_buf) begin
            running_total_register <= save_buffer;
          end
        end
        OP_KEEP_MAX: begin
          if (acc_lt_buf) begin
            running_total_register <= save_buffer;
          end
        end
        OP_REPEAT_CLEAR: running_total_register <= ACC_RESET;
        default: ; // stores, bit logic and loads keep the accumulator
      endcase
    end
  end
  // save buffer: fast save, and the other side of min and max
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      save_buffer <= ACC_RESET;
    end else if (go) begin
      if (cmd.op == OP_SAVE_BUFFER) begin
        save_buffer <= running_total_register;
      end else if (cmd.op == OP_KEEP_MIN && acc_lt_buf) begin
        save_buffer <= running_total_register;
      end else if (cmd.op == OP_KEEP_MAX && !acc_lt_buf) begin
        save_buffer <= running_total_register;
      end
    end
  end
  // flags: carry from add, subtract and compare; test from bit logic and left justify
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      carry <= 1'b0;
      test_flag <= 1'b0;
    end else if (go) begin
      unique case (cmd.op)
        OP_ADD_SHIFTED, OP_ADD_PRODUCT, OP_ADD_BUFFER: carry <= sum33[32];
        OP_SUB_SHIFTED: carry <= ~diff33[32];
        OP_KEEP_MIN: carry <= acc_lt_buf;
        OP_KEEP_MAX: carry <= !acc_lt_buf && (running_total_register != save_buffer);
        OP_BIT_LOGIC: test_flag <= (data_in & cmd.imm) != WORD_RESET;
        OP_LEFT_JUSTIFY: test_flag <= !justify_now;
        default: ; // other steps leave both flags alone
      endcase
    end
  end
  // multiplier: operand register and product register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      multiplier_operand_register <= WORD_RESET;
      product_register <= ACC_RESET;
    end else if (go) begin
      unique case (cmd.op)
        OP_LOAD_OPERAND: multiplier_operand_register <= data_in;
        OP_MUL_SIGNED: product_register <= mul_signed;
        OP_MUL_UNSIGNED: product_register <= mul_unsigned;
        OP_MUL_ACC, OP_MUL_ACC_MOVE: begin
          // the old product is accumulated while the new one forms
          multiplier_operand_register <= data_in;
          product_register <= mac_product;
        end
        OP_REPEAT_CLEAR: product_register <= ACC_RESET;
        default: ; // no multiplier activity
      endcase
    end
  end
  // shift count and index registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shift_count_register <= WORD_RESET;
      index_step_register <= WORD_RESET;
    end else if (go) begin
      if (cmd.op == OP_LOAD_SHIFT_COUNT) begin
        shift_count_register <= data_in;
      end
      if (cmd.op == OP_LOAD_INDEX) begin
        index_step_register <= data_in;
      end
    end
  end
  // address arithmetic unit, separate from the main alu
  always_comb begin
    unique case (cmd.addr_mode)
      AR_INC: aux_step = cur_aux + 16'h0001;
      AR_DEC: aux_step = cur_aux - 16'h0001;
      AR_ADD_INDEX: aux_step = cur_aux + index_step_register;
      AR_SUB_INDEX: aux_step = cur_aux - index_step_register;
      default: aux_step = cur_aux;
    endcase
  end
  // source of an auxiliary register load
  always_comb begin
    unique case (cmd.aux_src)
      AUX_FROM_ACC: aux_load = running_total_register[15:0];
      AUX_FROM_PROD: aux_load = product_register[15:0];
      AUX_FROM_IMM: aux_load = cmd.imm;
      default: aux_load = data_in;
    endcase
  end
  // auxiliary register file; a load beats an autoindex on the same entry
  for (genvar i = 0; i < AUX_COUNT; i++) begin : g_aux
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        auxiliary_pointer_regs[i] <= WORD_RESET;
      end else if (go && cmd.op == OP_LOAD_AUX && cmd.ptr_next == 3'(i)) begin
        auxiliary_pointer_regs[i] <= aux_load;
      end else if (go && pointer_select == 3'(i)) begin
        auxiliary_pointer_regs[i] <= aux_step;
      end
    end
  end
  // pointer, address in use and the mapped read port
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pointer_select <= PTR_RESET;
      data_addr <= WORD_RESET;
      map_value <= WORD_RESET;
    end else begin
      map_value <= auxiliary_pointer_regs[map_select];
      if (go) begin
        data_addr <= cur_aux;
        if (cmd.ptr_load && cmd.op != OP_LOAD_AUX) begin
          pointer_select <= cmd.ptr_next;
        end
      end
    end
  end
  // bit logic unit works on the fetched word, never on the accumulator
  always_comb begin
    unique case (cmd.bit_op)
      BIT_SET: bit_result = data_in | cmd.imm;
      BIT_CLEAR: bit_result = data_in & ~cmd.imm;
      BIT_TOGGLE: bit_result = data_in ^ cmd.imm;
      default: bit_result = data_in;
    endcase
  end
  // write port: stores, bit logic results and sample moves
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_en <= 1'b0;
      wr_addr <= WORD_RESET;
      wr_data <= WORD_RESET;
    end else begin
      wr_en <= 1'b0;
      if (go) begin
        wr_addr <= cur_aux;
        unique case (cmd.op)
          OP_STORE_HIGH: begin
            wr_en <= 1'b1;
            wr_data <= 16'(running_total_register >> (HALF_SHIFT - 5'(cmd.post_shift)));
          end
          OP_STORE_LOW: begin
            wr_en <= 1'b1;
            wr_data <= running_total_register[15:0] << cmd.post_shift;
          end
          OP_BIT_LOGIC: wr_en <= cmd.bit_op != BIT_TEST;
          OP_MUL_ACC_MOVE: begin
            // the consumed sample moves up one word, dropping the oldest
            wr_en <= 1'b1;
            wr_addr <= cur_aux + 16'h0001;
            wr_data <= data_in;
          end
          default: ; // nothing to write
        endcase
        if (cmd.op == OP_BIT_LOGIC) begin
          wr_data <= bit_result;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence load_step;
    go && cmd.op == OP_LOAD_OPERAND;
  endsequence
  sequence mul_step;
    go && cmd.op == OP_MUL_SIGNED;
  endsequence
  repeat_clear_a: assert property (go && cmd.op == OP_REPEAT_CLEAR |=>
    running_total_register == ACC_RESET && product_register == ACC_RESET)
    else $error("repeat clear left state");
  save_copy_a: assert property (go && cmd.op == OP_SAVE_BUFFER |=>
    save_buffer == $past(running_total_register))
    else $error("save buffer copy wrong");
  store_low_a: assert property (go && cmd.op == OP_STORE_LOW |=> wr_en &&
    wr_data == 16'($past(running_total_register) << $past(cmd.post_shift))
    && $stable(running_total_register))
    else $error("low store wrong");
  store_high_a: assert property (go && cmd.op == OP_STORE_HIGH |=> wr_en &&
    wr_data == 16'(($past(running_total_register) << $past(cmd.post_shift)) >> HIGH_LOW))
    else $error("high store wrong");
  load_mul_a: assert property (load_step ##1 mul_step |=>
    $signed(product_register) == $signed($past(data_in, 2)) * $signed($past(data_in)))
    else $error("two-cycle product wrong");
  keep_min_a: assert property (go && cmd.op == OP_KEEP_MIN |=>
    running_total_register == save_buffer && carry == $past(acc_lt_buf))
    else $error("minimum not kept");
  aux_step_a: assert property (go && cmd.op != OP_LOAD_AUX && cmd.addr_mode == AR_INC |=>
    auxiliary_pointer_regs[$past(pointer_select)] == $past(cur_aux) + 16'h0001)
    else $error("address step wrong");
  acc_hold_a: assert property (go && cmd.op == OP_BIT_LOGIC |=>
    $stable(running_total_register) ##1 (!wr_en || $past(go)))
    else $error("bit logic touched accumulator");
endmodule

/* File: verif/data_memory_model.sv */
// behavioural data memory on the far side of the datapath write port
`timescale 1ns/1ps
module data_memory_model (
  // clock
  input wire logic clk_sys,
  // write port from the datapath
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read port for the bench
  input wire logic [15:0] rd_addr,
  output logic [15:0] rd_data
);
  // small window of data space; unwritten words hold a marker, not zero
  logic [15:0] mem [0:511];
  // fill with the marker so a missed write never reads as a lucky match
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 16'ha5a5;
    end
  end
  // capture each one-cycle write pulse at the edge that sees it
  always @(posedge clk_sys) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr[8:0]] <= wr_data;
    end
  end
  // read is immediate; the bench samples it between edges
  assign rd_data = mem[rd_addr[8:0]];
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the signal-processor datapath
`timescale 1ns/1ps
module tb_top;
  import dsp_core_pkg::*;
  // stimulus
  logic clk_sys, resetn, cmd_valid;
  cmd_type cmd;
  status_word_two_type sw;
  logic [15:0] data_in, coeff_in, rd_addr, rd_data;
  logic [2:0] map_select, pointer;
  // observed state
  logic wr_en, carry, test_flag;
  logic [15:0] wr_addr, wr_data, data_addr, map_value, operand, shift_count, index_step;
  logic [31:0] acc, buffer, product;
  // product-shift expectations for a product of -6, modes 0 to 3
  logic [31:0] shift_exp [4] = '{32'hfffffffa, 32'hfffffff4, 32'hffffffa0, 32'hffffffff};
  int n_mismatch = 0;
  int n_tests = 0;

  // 100 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  dsp_core_datapath u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .status_word_two(sw), .data_in(data_in), .coeff_in(coeff_in),
    .map_select(map_select), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .data_addr(data_addr), .map_value(map_value), .pointer_select(pointer),
    .running_total_register(acc), .save_buffer(buffer), .product_register(product),
    .multiplier_operand_register(operand), .shift_count_register(shift_count),
    .index_step_register(index_step), .carry(carry), .test_flag(test_flag)
  );

  data_memory_model u_mem (
    .clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data)
  );

  // compare and count; case inequality so an unknown never passes
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one taken step; returns 1 ns after the edge, once results have landed
  task automatic go(input op_type o, input logic [15:0] d, input logic [4:0] sh);
    cmd.op = o;
    cmd.shift = sh;
    data_in = d;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask

  // a refused cycle: bus carries junk that must be ignored
  task automatic idle;
    cmd_valid = 1'b0;
    data_in = 16'hffff;
    @(posedge clk_sys);
    #1;
  endtask

  // load through the scaling shifter and check the running total
  task automatic ld(input logic s, input logic [4:0] sh, input logic [15:0] d,
                    input logic [31:0] e);
    sw.sign_extend_mode_bit = s;
    go(OP_LOAD_SHIFTED, d, sh);
    chk(acc, e);
  endtask

  // keep-min/keep-max: both registers and the carry
  task automatic mm(input op_type o, input logic [31:0] v, input logic c);
    go(o, 16'h0000, 5'h00);
    chk(buffer, v);
    chk(acc, v);
    chk(carry, c);
  endtask

  // one write through the bit logic unit at the current pointer
  task automatic bl(input bit_op_type b, input logic [15:0] d, input logic [15:0] m,
                    input logic [15:0] e);
    cmd.bit_op = b;
    cmd.imm = m;
    go(OP_BIT_LOGIC, d, 5'h00);
    chk(wr_en, 1'b1);
    chk(wr_data, e);
    chk(wr_addr, 16'h0100);
    chk(acc, 32'h81234567);
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  // single place where the run ends
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 200 cycles
  initial begin
    #20000;
    n_mismatch++;
    give_verdict;
  end

  // main sequence
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    sw = '0;
    data_in = 16'h0000;
    coeff_in = 16'h0000;
    map_select = 3'h0;
    rd_addr = 16'h0100;
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk(acc, 32'h0);
    chk(product, 32'h0);
    chk(pointer, 3'h0);
    done("reset");
    // scaling shifter: fill modes, full range and clamp
    ld(1'b1, 5'h04, 16'h8001, 32'hfff80010);
    ld(1'b0, 5'h04, 16'h8001, 32'h00080010);
    ld(1'b1, 5'h10, 16'h1234, 32'h12340000);
    ld(1'b0, 5'h00, 16'hffff, 32'h0000ffff);
    ld(1'b1, 5'h00, 16'hffff, 32'hffffffff);
    ld(1'b0, 5'h1f, 16'h0001, 32'h00010000);
    idle;
    chk(acc, 32'h00010000);
    done("scaling");
    // only the low four bits of the count register steer the shift
    go(OP_LOAD_SHIFT_COUNT, 16'h0013, 5'h00);
    chk(shift_count, 16'h0013);
    cmd.var_shift = 1'b1;
    ld(1'b0, 5'h00, 16'h0001, 32'h8);
    go(OP_ADD_SHIFTED, 16'h0001, 5'h00);
    chk(acc, 32'h10);
    go(OP_SUB_SHIFTED, 16'h0002, 5'h00);
    chk(acc, 32'h0);
    chk(carry, 1'b1);
    cmd.var_shift = 1'b0;
    done("variable shift");
    // save buffer as operand, then min and max
    ld(1'b0, 5'h00, 16'h0005, 32'h5);
    go(OP_SAVE_BUFFER, 16'h0000, 5'h00);
    chk(buffer, 32'h5);
    ld(1'b0, 5'h00, 16'h0009, 32'h9);
    go(OP_ADD_BUFFER, 16'h0000, 5'h00);
    chk(acc, 32'he);
    mm(OP_KEEP_MAX, 32'he, 1'b1);
    ld(1'b0, 5'h00, 16'h0003, 32'h3);
    mm(OP_KEEP_MIN, 32'h3, 1'b1);
    mm(OP_KEEP_MAX, 32'h3, 1'b0);
    done("buffer");
    // right shift by sixteen and by one, then left justify
    ld(1'b1, 5'h10, 16'h8000, 32'h80000000);
    go(OP_SHIFT_RIGHT, 16'h0000, 5'h10);
    chk(acc, 32'hffff8000);
    ld(1'b0, 5'h10, 16'h8000, 32'h80000000);
    go(OP_SHIFT_RIGHT, 16'h0000, 5'h01);
    chk(acc, 32'h40000000);
    go(OP_LEFT_JUSTIFY, 16'h0000, 5'h00);
    chk(acc, 32'h40000000);
    chk(test_flag, 1'b1);
    ld(1'b0, 5'h00, 16'h0001, 32'h1);
    go(OP_LEFT_JUSTIFY, 16'h0000, 5'h00);
    chk(acc, 32'h2);
    chk(test_flag, 1'b0);
    done("shifts");
    // operand load then multiply, back to back
    go(OP_LOAD_OPERAND, 16'hfffe, 5'h00);
    chk(operand, 16'hfffe);
    go(OP_MUL_SIGNED, 16'h0003, 5'h00);
    chk(product, 32'hfffffffa);
    go(OP_MUL_UNSIGNED, 16'h0003, 5'h00);
    chk(product, 32'h0002fffa);
    go(OP_MUL_SIGNED, 16'h0003, 5'h00);
    for (int i = 0; i < 4; i++) begin
      sw.product_shift_field = 2'(i);
      go(OP_LOAD_SHIFTED, 16'h0000, 5'h00);
      go(OP_ADD_PRODUCT, 16'h0000, 5'h00);
      chk(acc, shift_exp[i]);
    end
    chk(product, 32'hfffffffa);
    done("multiply");
    // clear then two accumulating steps
    sw.product_shift_field = PROD_NONE;
    go(OP_REPEAT_CLEAR, 16'h0000, 5'h00);
    chk(acc, 32'h0);
    chk(product, 32'h0);
    coeff_in = 16'h0003;
    go(OP_MUL_ACC, 16'h0002, 5'h00);
    chk(product, 32'h6);
    coeff_in = 16'h0005;
    go(OP_MUL_ACC, 16'h0004, 5'h00);
    chk(acc, 32'h6);
    chk(product, 32'h14);
    done("mac");
    // auxiliary register load, pointer and mapped view
    map_select = 3'h2;
    cmd.aux_src = AUX_FROM_IMM;
    cmd.imm = 16'h0100;
    cmd.ptr_next = 3'h2;
    go(OP_LOAD_AUX, 16'h0000, 5'h00);
    cmd.ptr_load = 1'b1;
    go(OP_NOP, 16'h0000, 5'h00);
    chk(map_value, 16'h0100);
    chk(pointer, 3'h2);
    cmd.ptr_load = 1'b0;
    // stores with post-shift; the total must not move
    ld(1'b0, 5'h10, 16'h8123, 32'h81230000);
    go(OP_ADD_SHIFTED, 16'h4567, 5'h00);
    cmd.post_shift = 3'h4;
    cmd.addr_mode = AR_INC;
    go(OP_STORE_HIGH, 16'h0000, 5'h00);
    chk(wr_data, 16'h1234);
    chk(data_addr, 16'h0100);
    cmd.post_shift = 3'h7;
    cmd.addr_mode = AR_HOLD;
    go(OP_STORE_LOW, 16'h0000, 5'h00);
    chk(wr_addr, 16'h0101);
    chk(wr_data, 16'hb380);
    chk(acc, 32'h81234567);
    go(OP_LOAD_INDEX, 16'h0010, 5'h00);
    chk(index_step, 16'h0010);
    chk(wr_en, 1'b0);
    chk(rd_data, 16'h1234);
    // index steps seen one cycle late on the mapped view
    cmd.addr_mode = AR_ADD_INDEX;
    go(OP_NOP, 16'h0000, 5'h00);
    cmd.addr_mode = AR_DEC;
    go(OP_NOP, 16'h0000, 5'h00);
    chk(map_value, 16'h0111);
    cmd.addr_mode = AR_SUB_INDEX;
    go(OP_NOP, 16'h0000, 5'h00);
    chk(map_value, 16'h0110);
    cmd.addr_mode = AR_HOLD;
    go(OP_NOP, 16'h0000, 5'h00);
    chk(map_value, 16'h0100);
    done("aux and store");
    // bit logic on memory, every operation
    bl(BIT_SET, 16'h000f, 16'h0100, 16'h010f);
    bl(BIT_CLEAR, 16'h0f0f, 16'h000f, 16'h0f00);
    bl(BIT_TOGGLE, 16'h00ff, 16'h0f0f, 16'h0ff0);
    cmd.bit_op = BIT_TEST;
    cmd.imm = 16'h0010;
    go(OP_BIT_LOGIC, 16'h00f0, 5'h00);
    chk(test_flag, 1'b1);
    chk(wr_en, 1'b0);
    chk(rd_data, 16'h0ff0);
    done("bit logic");
    // moving mac writes the sample one place up
    rd_addr = 16'h0101;
    coeff_in = 16'h0001;
    go(OP_MUL_ACC_MOVE, 16'habcd, 5'h00);
    chk(wr_addr, 16'h0101);
    idle;
    chk(rd_data, 16'habcd);
    done("moving mac");
    give_verdict;
  end
endmodule
